//--- shared/ppp_if.sv
// pin bundle between programmer and device
interface ppp_if;
  logic action_select_hi;
  logic action_select_lo;
  logic byte_select_first;
  logic byte_select_second;
  logic load_strobe_clock;
  logic page_latch_strobe;
  logic write_pulse_n;
  logic output_enable_n;
  logic ready_busy_flag;
  logic [7:0] data_h2d;
  logic data_h_oe;
  logic [7:0] data_d2h;
  logic data_d_oe;
  logic [7:0] data_bus;
  // resolved bus level, released bus reads high
  assign data_bus = data_d_oe ? data_d2h : (data_h_oe ? data_h2d : 8'hff);
  modport device (
    input action_select_hi, action_select_lo, byte_select_first, byte_select_second,
    input load_strobe_clock, page_latch_strobe, write_pulse_n, output_enable_n, data_bus,
    output ready_busy_flag, data_d2h, data_d_oe
  );
  modport host (
    output action_select_hi, action_select_lo, byte_select_first, byte_select_second,
    output load_strobe_clock, page_latch_strobe, write_pulse_n, output_enable_n,
    output data_h2d, data_h_oe,
    input ready_busy_flag, data_bus
  );
endinterface

//--- shared/ppp_pkg.sv
// constants and types for the parallel programming port
// Contract
// - action 10, low select: strobe loads command
// - action 00: strobe loads address low/high byte
// - action 01: strobe loads data low/high byte
// - page latch copies data into page buffer
// - low bits word, upper bits page
// - write-flash pulse programs page, busy until done
// - command zero clears internal write state
// - eeprom page write with byte select low
// - read flash low/high byte under output enable
// - read eeprom byte under output enable
// - fuse write targets low, high, extended fuses
// - host returns byte selects low after fuse write
// - lock write refused once lock mode three
// - lock bits cleared only by chip erase; the code also sets them back to LOCK_RST on presetn
// - read fuses and lock bits by selects
// - read identification bytes at addresses 0..2
// - address zero, select high reads calibration
// - ready flag low while programming, else high
// - device drives data only while output enable low; the code registers it, so driving starts and ends one pclk late
package ppp_pkg;
  localparam logic [1:0] ACT_ADDR = 2'b00;
  localparam logic [1:0] ACT_DATA = 2'b01;
  localparam logic [1:0] ACT_CMD = 2'b10;
  localparam logic [1:0] ACT_IDLE = 2'b11;
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE = 8'h11;
  localparam logic [7:0] CMD_RD_ID = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE = 8'h03;
  // memory organisation
  localparam int FLASH_WORDS = 4096;
  localparam int FLASH_PAGE_WORDS = 32;
  localparam int EE_BYTES = 64;
  localparam int EE_PAGE_BYTES = 4;
  localparam logic [7:0] FUSE_LO_RST = 8'hff;
  localparam logic [7:0] FUSE_HI_RST = 8'hff;
  localparam logic [7:0] FUSE_EXT_RST = 8'hff;
  localparam logic [7:0] LOCK_RST = 8'hff;
  // identification bytes, values arbitrary
  localparam logic [7:0] ID_BYTE0 = 8'h5a;
  localparam logic [7:0] ID_BYTE1 = 8'h3c;
  localparam logic [7:0] ID_BYTE2 = 8'h0f;
  // timing
  localparam int CLK_NS = 50;
  localparam int PULSE_NS = 250;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROG_US = 4500;
  localparam int PROG_CYC = PROG_US * 1000 / CLK_NS;
  // host register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_BS1 = 4;
  localparam int CTRL_BS2 = 5;
  localparam int CTRL_DATA_LSB = 8;
  localparam int STAT_BUSY = 0;
  localparam int STAT_RDY = 1;
  localparam int STAT_DATA_LSB = 8;
  localparam logic [2:0] OP_CMD = 3'h0;
  localparam logic [2:0] OP_ADDR_LO = 3'h1;
  localparam logic [2:0] OP_ADDR_HI = 3'h2;
  localparam logic [2:0] OP_DATA_LO = 3'h3;
  localparam logic [2:0] OP_DATA_HI = 3'h4;
  localparam logic [2:0] OP_LATCH = 3'h5;
  localparam logic [2:0] OP_WRITE = 3'h6;
  localparam logic [2:0] OP_READ = 3'h7;
  typedef enum logic [1:0] {JOB_NONE, JOB_FLASH, JOB_EE, JOB_MISC} ppp_job_t;
  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_PULSE, H_WAIT} ppp_hstate_t;
endpackage

//--- src/ppp_device.sv
// programming port logic of the device end
//
// The implementer's own choices: the address map; the APB register port sits in ppp_host.
module ppp_device
  import ppp_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  ppp_if.device io,
  input wire logic chip_erase_done,
  input wire logic [7:0] osc_cal,
  output logic [7:0] fuse_lo,
  output logic [7:0] fuse_hi,
  output logic [7:0] fuse_ext,
  output logic [7:0] lock_bits
);
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] addr_lo;
    logic [7:0] addr_hi;
    logic [7:0] data_lo;
    logic [7:0] data_hi;
    logic lsc_q;
    logic pls_q;
    logic wr_q;
    logic armed;
    logic busy;
    logic [19:0] cnt;
    ppp_job_t job;
    logic [6:0] page;
    logic [5:0] widx;
    logic [7:0] fuse_lo;
    logic [7:0] fuse_hi;
    logic [7:0] fuse_ext;
    logic [7:0] lock;
    logic [7:0] dout;
    logic doe;
    logic rdy;
  } ppp_dev_st_t;

  ppp_dev_st_t s_r, s_nxt;
  logic [15:0] flash_mem [FLASH_WORDS];
  logic [15:0] flash_buf [FLASH_PAGE_WORDS];
  logic [7:0] ee_mem [EE_BYTES];
  logic [7:0] ee_buf [EE_PAGE_BYTES];
  logic fl_we, fb_we, ee_we, eb_we;
  logic [11:0] fl_wa;
  logic [4:0] fb_wa;
  logic [5:0] ee_wa;
  logic [1:0] eb_wa;
  logic [11:0] rd_word;
  logic [15:0] rd_flash;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_nxt = s_r;
    fl_we = 1'b0;
    fb_we = 1'b0;
    ee_we = 1'b0;
    eb_we = 1'b0;
    fl_wa = {s_r.page, s_r.widx[4:0]};
    fb_wa = s_r.addr_lo[4:0];
    ee_wa = {s_r.page[3:0], s_r.widx[1:0]};
    eb_wa = s_r.addr_lo[1:0];
    rd_word = {s_r.addr_hi[3:0], s_r.addr_lo};
    rd_flash = flash_mem[rd_word];
    s_nxt.lsc_q = io.load_strobe_clock;
    s_nxt.pls_q = io.page_latch_strobe;
    s_nxt.wr_q = io.write_pulse_n;
    // strobe loads
    if (io.load_strobe_clock && !s_r.lsc_q && !s_r.busy) begin
      case ({io.action_select_hi, io.action_select_lo})
        ACT_CMD: begin
          if (!io.byte_select_first) begin
            s_nxt.cmd = io.data_bus;
            s_nxt.armed = (io.data_bus != CMD_NOP);
          end
        end
        ACT_ADDR: begin
          if (io.byte_select_first) begin
            s_nxt.addr_hi = io.data_bus;
          end else begin
            s_nxt.addr_lo = io.data_bus;
          end
        end
        ACT_DATA: begin
          if (io.byte_select_first) begin
            s_nxt.data_hi = io.data_bus;
          end else begin
            s_nxt.data_lo = io.data_bus;
          end
        end
        default: begin
        end
      endcase
    end
    // page latch
    if (io.page_latch_strobe && !s_r.pls_q && !s_r.busy && s_r.armed) begin
      if (s_r.cmd == CMD_WR_FLASH) begin
        fb_we = 1'b1;
      end else if (s_r.cmd == CMD_WR_EE) begin
        eb_we = 1'b1;
      end
    end
    // write pulse starts an operation
    if (!io.write_pulse_n && s_r.wr_q && !s_r.busy && s_r.armed) begin
      s_nxt.cnt = 20'(PROG_CYCLES - 1);
      s_nxt.widx = 6'h00;
      s_nxt.job = JOB_MISC;
      s_nxt.busy = 1'b1;
      s_nxt.rdy = 1'b0;
      if (s_r.cmd == CMD_WR_FLASH) begin
        s_nxt.job = JOB_FLASH;
        s_nxt.page = {s_r.addr_hi[3:0], s_r.addr_lo[7:5]};
      end else if (s_r.cmd == CMD_WR_EE && !io.byte_select_first) begin
        s_nxt.job = JOB_EE;
        s_nxt.page = {3'h0, s_r.addr_lo[5:2]};
      end else if (s_r.cmd == CMD_WR_FUSE) begin
        if (!io.byte_select_first && !io.byte_select_second) begin
          s_nxt.fuse_lo = s_r.data_lo;
        end else if (io.byte_select_first && !io.byte_select_second) begin
          s_nxt.fuse_hi = s_r.data_lo;
        end else if (!io.byte_select_first && io.byte_select_second) begin
          s_nxt.fuse_ext = s_r.data_lo;
        end
      end else if (s_r.cmd == CMD_WR_LOCK) begin
        if (s_r.lock[1:0] != 2'b00) begin
          s_nxt.lock = s_r.lock & {6'h3f, s_r.data_lo[1:0]};
        end
      end else begin
        s_nxt.busy = 1'b0;
        s_nxt.rdy = 1'b1;
        s_nxt.job = JOB_NONE;
      end
    end
    // self-timed programming
    if (s_r.busy) begin
      if (s_r.job == JOB_FLASH && s_r.widx < 6'(FLASH_PAGE_WORDS)) begin
        fl_we = 1'b1;
        s_nxt.widx = s_r.widx + 6'h01;
      end else if (s_r.job == JOB_EE && s_r.widx < 6'(EE_PAGE_BYTES)) begin
        ee_we = 1'b1;
        s_nxt.widx = s_r.widx + 6'h01;
      end
      if (s_r.cnt == 20'h00000) begin
        s_nxt.busy = 1'b0;
        s_nxt.rdy = 1'b1;
        s_nxt.job = JOB_NONE;
      end else begin
        s_nxt.cnt = s_r.cnt - 20'h00001;
      end
    end
    if (chip_erase_done) begin
      s_nxt.lock = LOCK_RST;
    end
    // readback
    s_nxt.doe = !io.output_enable_n;
    s_nxt.dout = 8'hff;
    if (!io.output_enable_n) begin
      case (s_r.cmd)
        CMD_RD_FLASH: begin
          s_nxt.dout = io.byte_select_first ? rd_flash[15:8] : rd_flash[7:0];
        end
        CMD_RD_EE: begin
          if (!io.byte_select_first) begin
            s_nxt.dout = ee_mem[s_r.addr_lo[5:0]];
          end
        end
        CMD_RD_FUSE: begin
          case ({io.byte_select_second, io.byte_select_first})
            2'b00: s_nxt.dout = s_r.fuse_lo;
            2'b11: s_nxt.dout = s_r.fuse_hi;
            2'b10: s_nxt.dout = s_r.fuse_ext;
            default: s_nxt.dout = s_r.lock;
          endcase
        end
        CMD_RD_ID: begin
          if (io.byte_select_first) begin
            if (s_r.addr_lo == 8'h00) begin
              s_nxt.dout = osc_cal;
            end
          end else if (s_r.addr_lo == 8'h00) begin
            s_nxt.dout = ID_BYTE0;
          end else if (s_r.addr_lo == 8'h01) begin
            s_nxt.dout = ID_BYTE1;
          end else if (s_r.addr_lo == 8'h02) begin
            s_nxt.dout = ID_BYTE2;
          end
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.lsc_q <= 1'b0;
      s_r.pls_q <= 1'b0;
      s_r.wr_q <= 1'b1;
      s_r.job <= JOB_NONE;
      s_r.fuse_lo <= FUSE_LO_RST;
      s_r.fuse_hi <= FUSE_HI_RST;
      s_r.fuse_ext <= FUSE_EXT_RST;
      s_r.lock <= LOCK_RST;
      s_r.dout <= 8'hff;
      s_r.rdy <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memories
  always_ff @(posedge pclk) begin
    if (fb_we) begin
      flash_buf[fb_wa] <= {s_r.data_hi, s_r.data_lo};
    end
    if (eb_we) begin
      ee_buf[eb_wa] <= s_r.data_lo;
    end
    if (fl_we) begin
      flash_mem[fl_wa] <= flash_buf[s_r.widx[4:0]];
    end
    if (ee_we) begin
      ee_mem[ee_wa] <= ee_buf[s_r.widx[1:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign io.ready_busy_flag = s_r.rdy;
  assign io.data_d2h = s_r.dout;
  assign io.data_d_oe = s_r.doe;
  assign fuse_lo = s_r.fuse_lo;
  assign fuse_hi = s_r.fuse_hi;
  assign fuse_ext = s_r.fuse_ext;
  assign lock_bits = s_r.lock;
endmodule // ppp_device

//--- src/ppp_host.sv
// programmer end: apb registers drive pin sequences
module ppp_host
  import ppp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  ppp_if.host io
);
  typedef struct packed {
    ppp_hstate_t st;
    logic [2:0] op;
    logic [3:0] cnt;
    logic [7:0] rdata;
    logic xa1;
    logic xa0;
    logic bs1;
    logic bs2;
    logic lsc;
    logic pls;
    logic wr_n;
    logic oe_n;
    logic [7:0] dout;
    logic doe;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ppp_host_st_t;

  ppp_host_st_t h_r, h_nxt;
  logic acc;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    h_nxt = h_r;
    acc = psel && penable && h_r.pready;
    h_nxt.pready = psel && penable && !h_r.pready;
    if (psel && penable && !h_r.pready) begin
      h_nxt.pslverr = (paddr != REG_CTRL) && (paddr != REG_STATUS);
      h_nxt.prdata = 32'h00000000;
      if (paddr == REG_STATUS) begin
        h_nxt.prdata[STAT_BUSY] = (h_r.st != H_IDLE);
        h_nxt.prdata[STAT_RDY] = io.ready_busy_flag;
        h_nxt.prdata[STAT_DATA_LSB +: 8] = h_r.rdata;
      end
    end
    case (h_r.st)
      H_IDLE: begin
        if (acc && pwrite && paddr == REG_CTRL) begin
          h_nxt.op = pwdata[CTRL_OP_LSB +: 3];
          h_nxt.dout = pwdata[CTRL_DATA_LSB +: 8];
          h_nxt.bs1 = pwdata[CTRL_BS1];
          h_nxt.bs2 = pwdata[CTRL_BS2];
          h_nxt.cnt = 4'(PULSE_CYC - 1);
          h_nxt.st = H_SETUP;
          h_nxt.doe = 1'b1;
          {h_nxt.xa1, h_nxt.xa0} = ACT_IDLE;
          case (pwdata[CTRL_OP_LSB +: 3])
            OP_CMD: begin
              {h_nxt.xa1, h_nxt.xa0} = ACT_CMD;
              h_nxt.bs1 = 1'b0;
            end
            OP_ADDR_LO: begin
              {h_nxt.xa1, h_nxt.xa0} = ACT_ADDR;
              h_nxt.bs1 = 1'b0;
            end
            OP_ADDR_HI: begin
              {h_nxt.xa1, h_nxt.xa0} = ACT_ADDR;
              h_nxt.bs1 = 1'b1;
            end
            OP_DATA_LO: begin
              {h_nxt.xa1, h_nxt.xa0} = ACT_DATA;
              h_nxt.bs1 = 1'b0;
            end
            OP_DATA_HI: begin
              {h_nxt.xa1, h_nxt.xa0} = ACT_DATA;
              h_nxt.bs1 = 1'b1;
            end
            OP_READ: begin
              h_nxt.doe = 1'b0;
            end
            default: begin
            end
          endcase
        end
      end
      H_SETUP: begin
        if (h_r.cnt == 4'h0) begin
          h_nxt.cnt = 4'(PULSE_CYC - 1);
          h_nxt.st = H_PULSE;
          case (h_r.op)
            OP_LATCH: h_nxt.pls = 1'b1;
            OP_WRITE: h_nxt.wr_n = 1'b0;
            OP_READ: h_nxt.oe_n = 1'b0;
            default: h_nxt.lsc = 1'b1;
          endcase
        end else begin
          h_nxt.cnt = h_r.cnt - 4'h1;
        end
      end
      H_PULSE: begin
        if (h_r.cnt == 4'h0) begin
          h_nxt.lsc = 1'b0;
          h_nxt.pls = 1'b0;
          h_nxt.wr_n = 1'b1;
          h_nxt.oe_n = 1'b1;
          h_nxt.doe = 1'b0;
          h_nxt.st = (h_r.op == OP_WRITE) ? H_WAIT : H_IDLE;
          if (h_r.op == OP_READ) begin
            h_nxt.rdata = io.data_bus;
          end
        end else begin
          h_nxt.cnt = h_r.cnt - 4'h1;
        end
      end
      H_WAIT: begin
        if (io.ready_busy_flag) begin
          h_nxt.bs1 = 1'b0;
          h_nxt.bs2 = 1'b0;
          h_nxt.st = H_IDLE;
        end
      end
      default: h_nxt.st = H_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_r <= '0;
      h_r.st <= H_IDLE;
      {h_r.xa1, h_r.xa0} <= ACT_IDLE;
      h_r.wr_n <= 1'b1;
      h_r.oe_n <= 1'b1;
    end else begin
      h_r <= h_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata = h_r.prdata;
  assign pready = h_r.pready;
  assign pslverr = h_r.pslverr;
  assign io.action_select_hi = h_r.xa1;
  assign io.action_select_lo = h_r.xa0;
  assign io.byte_select_first = h_r.bs1;
  assign io.byte_select_second = h_r.bs2;
  assign io.load_strobe_clock = h_r.lsc;
  assign io.page_latch_strobe = h_r.pls;
  assign io.write_pulse_n = h_r.wr_n;
  assign io.output_enable_n = h_r.oe_n;
  assign io.data_h2d = h_r.dout;
  assign io.data_h_oe = h_r.doe;
endmodule // ppp_host

//--- tb/parallel_hv_programming_port_test.sv
// testbench joining programmer and device ends, driven over apb
module parallel_hv_programming_port_test
  import ppp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PCYC = 40;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, chip_erase_done, want;
  logic [7:0] paddr, osc_cal, fuse_lo, fuse_hi, fuse_ext, lock_bits;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0] expq[$];
  int err_count = 0;
  int checked = 0;
  ppp_if link();
  ppp_host ppp_host_inst(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .io(link));
  ppp_device #(.PROG_CYCLES(PCYC)) ppp_device_inst(.pclk, .presetn, .io(link),
    .chip_erase_done, .osc_cal, .fuse_lo, .fuse_hi, .fuse_ext, .lock_bits);
  ppp_assertions #(.PROG_CYCLES(PCYC)) ppp_assertions_inst(.pclk, .presetn,
    .action_select_hi(link.action_select_hi), .action_select_lo(link.action_select_lo),
    .byte_select_first(link.byte_select_first), .byte_select_second(link.byte_select_second),
    .load_strobe_clock(link.load_strobe_clock), .page_latch_strobe(link.page_latch_strobe),
    .write_pulse_n(link.write_pulse_n), .output_enable_n(link.output_enable_n),
    .ready_busy_flag(link.ready_busy_flag), .data_d_oe(link.data_d_oe),
    .data_h_oe(link.data_h_oe), .data_bus(link.data_bus));
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic bail();
    err_count++;
    $display("BAD %0t wait limit reached", $time);
    tally_and_finish();
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) bail();
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic op(input logic [2:0] o, input logic b1, input logic b2, input logic [7:0] d);
    int n = 0;
    apb(1'b1, REG_CTRL, {16'h0, d, 2'b0, b2, b1, 1'b0, o});
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (rd[STAT_BUSY] !== 1'b0 && n < 200);
    if (rd[STAT_BUSY] !== 1'b0) bail();
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [8:0] e);
    expq.push_back(e);
    want <= 1'b1;
    apb(1'b0, a, 32'h0);
    want <= 1'b0;
  endtask
  task automatic rdx(input logic b1, input logic b2, input logic [7:0] e);
    op(OP_READ, b1, b2, 8'h00);
    chk_rd(REG_STATUS, {1'b0, e});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // result watcher: oldest note against each checked read
  always @(posedge pclk) begin
    if (want && psel && penable && pready && !pwrite) begin
      checked++;
      if (expq.size() == 0 || {pslverr, prdata[15:8]} !== expq[0]) begin
        err_count++;
        $display("BAD %0t read returned %h", $time, {pslverr, prdata[15:8]});
      end
      if (expq.size() > 0) void'(expq.pop_front());
    end
  end
  initial begin
    repeat (100000) @(posedge pclk);
    bail();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] fw [4];
    logic [7:0] ee [2];
    logic [7:0] fz [3];
    static logic [7:0] lv [4] = '{8'hfe, 8'hff, 8'hfc, 8'hf0};
    static logic [7:0] ids [3] = '{ID_BYTE0, ID_BYTE1, ID_BYTE2};
    logic [7:0] ea;
    logic [7:0] lk;
    void'($urandom(32'h06818c5c));
    foreach (fw[i]) fw[i] = 8'($urandom);
    foreach (ee[i]) ee[i] = 8'($urandom);
    foreach (fz[i]) fz[i] = 8'($urandom);
    ea = 8'($urandom) & 8'h3c;
    {psel, penable, pwrite, paddr, pwdata, want} = '0;
    presetn = 1'b0;
    chip_erase_done = 1'b0;
    osc_cal = 8'($urandom);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // flash page write, upper low-address bits pick the page
    op(OP_CMD, 1'b0, 1'b0, CMD_WR_FLASH);
    for (int i = 0; i < 2; i++) begin
      op(OP_ADDR_LO, 1'b0, 1'b0, 8'(224 + i));
      op(OP_DATA_LO, 1'b0, 1'b0, fw[2*i]);
      op(OP_DATA_HI, 1'b1, 1'b0, fw[2*i+1]);
      op(OP_LATCH, 1'b1, 1'b0, 8'h00);
    end
    op(OP_ADDR_HI, 1'b0, 1'b0, 8'h01);
    op(OP_WRITE, 1'b0, 1'b0, 8'h00);
    // no-op disarms: later latch and write leave the word alone
    op(OP_CMD, 1'b0, 1'b0, CMD_NOP);
    op(OP_ADDR_LO, 1'b0, 1'b0, 8'd224);
    op(OP_DATA_LO, 1'b0, 1'b0, ~fw[0]);
    op(OP_LATCH, 1'b1, 1'b0, 8'h00);
    op(OP_WRITE, 1'b0, 1'b0, 8'h00);
    // rearm and reprogram: a latch taken under no-op would show here
    op(OP_CMD, 1'b0, 1'b0, CMD_WR_FLASH);
    op(OP_WRITE, 1'b0, 1'b0, 8'h00);
    op(OP_CMD, 1'b0, 1'b0, CMD_RD_FLASH);
    for (int i = 0; i < 2; i++) begin
      op(OP_ADDR_LO, 1'b0, 1'b0, 8'(224 + i));
      rdx(1'b0, 1'b0, fw[2*i]);
      rdx(1'b1, 1'b0, fw[2*i+1]);
    end
    // two bytes into a four-byte eeprom page
    op(OP_CMD, 1'b0, 1'b0, CMD_WR_EE);
    op(OP_ADDR_HI, 1'b0, 1'b0, 8'h00);
    for (int i = 0; i < 2; i++) begin
      op(OP_ADDR_LO, 1'b0, 1'b0, 8'(ea + i));
      op(OP_DATA_LO, 1'b0, 1'b0, ee[i]);
      op(OP_LATCH, 1'b1, 1'b0, 8'h00);
    end
    op(OP_WRITE, 1'b0, 1'b0, 8'h00);
    op(OP_CMD, 1'b0, 1'b0, CMD_RD_EE);
    for (int i = 0; i < 2; i++) begin
      op(OP_ADDR_LO, 1'b0, 1'b0, 8'(ea + i));
      rdx(1'b0, 1'b0, ee[i]);
    end
    // fuses: low, high, extended targets
    op(OP_CMD, 1'b0, 1'b0, CMD_WR_FUSE);
    for (int i = 0; i < 3; i++) begin
      op(OP_DATA_LO, 1'b0, 1'b0, fz[i]);
      op(OP_WRITE, i == 1, i == 2, 8'h00);
    end
    op(OP_CMD, 1'b0, 1'b0, CMD_RD_FUSE);
    rdx(1'b0, 1'b0, fz[0]);
    rdx(1'b1, 1'b1, fz[1]);
    rdx(1'b0, 1'b1, fz[2]);
    // lock bits only ever programmed, frozen at mode three
    lk = 8'hff;
    foreach (lv[i]) begin
      op(OP_CMD, 1'b0, 1'b0, CMD_WR_LOCK);
      op(OP_DATA_LO, 1'b0, 1'b0, lv[i]);
      op(OP_WRITE, 1'b0, 1'b0, 8'h00);
      if (lk[1:0] != 2'b00) lk = lk & lv[i];
      op(OP_CMD, 1'b0, 1'b0, CMD_RD_FUSE);
      rdx(1'b1, 1'b0, lk);
    end
    @(posedge pclk);
    chip_erase_done <= 1'b1;
    @(posedge pclk);
    chip_erase_done <= 1'b0;
    rdx(1'b1, 1'b0, 8'hff);
    // identification and calibration bytes
    op(OP_CMD, 1'b0, 1'b0, CMD_RD_ID);
    for (int i = 0; i < 3; i++) begin
      op(OP_ADDR_LO, 1'b0, 1'b0, 8'(i));
      rdx(1'b0, 1'b0, ids[i]);
    end
    op(OP_ADDR_LO, 1'b0, 1'b0, 8'h00);
    rdx(1'b1, 1'b0, osc_cal);
    chk_rd(8'h08, {1'b1, 8'h00});
    repeat (4) @(posedge pclk);
    checked++;
    if ({fuse_lo, fuse_hi, fuse_ext, lock_bits} !== {fz[0], fz[1], fz[2], 8'hff}) begin
      err_count++;
      $display("BAD %0t fuse or lock outputs %h", $time, {fuse_lo, fuse_hi, fuse_ext, lock_bits});
    end
    tally_and_finish();
  end
endmodule // parallel_hv_programming_port_test

//--- tb/ppp_assertions.sv
// concurrent checks on the programming port pins
module ppp_assertions
  import ppp_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic action_select_hi,
  input wire logic action_select_lo,
  input wire logic byte_select_first,
  input wire logic byte_select_second,
  input wire logic load_strobe_clock,
  input wire logic page_latch_strobe,
  input wire logic write_pulse_n,
  input wire logic output_enable_n,
  input wire logic ready_busy_flag,
  input wire logic data_d_oe,
  input wire logic data_h_oe,
  input wire logic [7:0] data_bus
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lsc_q_r;
  logic wr_q_r;
  logic [7:0] cmd_r;
  logic [31:0] busy_cnt_r;
  logic wr_fall;
  logic is_wcmd;
  assign wr_fall = wr_q_r && !write_pulse_n;
  assign is_wcmd = (cmd_r == CMD_WR_FLASH) || (cmd_r == CMD_WR_EE) ||
                   (cmd_r == CMD_WR_FUSE) || (cmd_r == CMD_WR_LOCK);
  ////////////////////////////////////////////////////////////////////////////
  // loaded command and busy length tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lsc_q_r <= 1'b0;
      wr_q_r <= 1'b1;
      cmd_r <= CMD_NOP;
      busy_cnt_r <= 32'h0;
    end else begin
      lsc_q_r <= load_strobe_clock;
      wr_q_r <= write_pulse_n;
      busy_cnt_r <= ready_busy_flag ? 32'h0 : busy_cnt_r + 32'h1;
      if (!lsc_q_r && load_strobe_clock && ready_busy_flag && !byte_select_first &&
          {action_select_hi, action_select_lo} == ACT_CMD) begin
        cmd_r <= data_bus;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_five_high(logic s);
    s [*5] ##1 !s;
  endsequence
  a_strobe_width: assert property ($rose(load_strobe_clock) |-> s_five_high(load_strobe_clock))
    else $error("load strobe width wrong");
  a_strobe_steady: assert property (load_strobe_clock && $past(load_strobe_clock) |->
    $stable(data_bus) && $stable({action_select_hi, action_select_lo, byte_select_first}))
    else $error("bus moved under load strobe");
  a_latch_width: assert property ($rose(page_latch_strobe) |-> s_five_high(page_latch_strobe))
    else $error("latch strobe width wrong");
  a_busy_start: assert property (wr_fall && ready_busy_flag && is_wcmd |=> !ready_busy_flag)
    else $error("write pulse did not start busy");
  a_busy_length: assert property ($rose(ready_busy_flag) |-> busy_cnt_r == 32'(PROG_CYCLES))
    else $error("busy length wrong");
  a_nop_idle: assert property (wr_fall && ready_busy_flag && cmd_r == CMD_NOP |=>
    ready_busy_flag [*2])
    else $error("write after no-op started busy");
  a_host_waits: assert property (!ready_busy_flag |->
    !$rose(load_strobe_clock) && !$rose(page_latch_strobe))
    else $error("strobe while busy");
  a_fuse_sel_back: assert property ($rose(ready_busy_flag) && cmd_r == CMD_WR_FUSE |->
    ##[1:4] !byte_select_first && !byte_select_second)
    else $error("byte selects not returned low");
  a_bus_single: assert property (!(data_d_oe && data_h_oe))
    else $error("both ends drive the bus");
  a_oe_gate: assert property (data_d_oe |-> !$past(output_enable_n))
    else $error("device drives without output enable");
  a_oe_release: assert property ($rose(output_enable_n) |=> !data_d_oe)
    else $error("device holds bus after output enable");
endmodule // ppp_assertions
